// *** sim/rqw_dev_model.sv ***
// Device end of the request stream: random back-pressure plus hold checks
module rqw_dev_model #(
  parameter logic [2:0] ATTR_EN = 3'h7
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        valid,
  input  wire logic        last,
  input  wire logic [1:0]  keep,
  input  wire logic [63:0] data,
  input  wire logic [59:0] sb,
  output logic             ready,
  output int               n_viol
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [127:0] prev;
  logic [2:0]   attr_sent;
  int           beat;
  logic         pv;
  logic         pr;
  logic         pl;

  initial begin
    ready = 1'b0;
    n_viol = 0;
    pv = 1'b0;
    pr = 1'b0;
    pl = 1'b1;
    prev = '0;
    attr_sent = '0;
    beat = 0;
  end

  // Stalls land at random so the two-entry buffer gets exercised
  always @(posedge clk) begin
    if (!srst && pv && !pr && {valid, last, keep, data, sb} !== prev) begin
      n_viol++;
    end
    if (!srst && pv && pr && !pl && valid !== 1'b1) begin
      n_viol++;
    end
    // Device zeroes attributes its function has not enabled
    if (!srst && valid && ready) begin
      if (beat == 1) attr_sent = data[62:60] & ATTR_EN;
      beat = last ? 0 : beat + 1;
    end
    pv = valid;
    pr = ready;
    pl = last;
    prev = {valid, last, keep, data, sb};
    #10;
    ready <= ($urandom_range(3) != 0);
  end
endmodule

// *** sim/tb_top.sv ***
module tb_top import rqw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [63:0] d;
    logic        l;
    logic [1:0]  k;
    logic [11:0] sb;
    bit          sbm;
  } rqw_exp_t;

  logic        clk, srst, mode, cv, cr, dig, cerr, plv, plr, abt;
  logic        sv, srdy, sl;
  rqw_kind_t   kind;
  logic [63:0] addr, pld, sd;
  logic [31:0] mid;
  logic [7:0]  tag, code;
  logic [2:0]  route, tc, attr;
  logic [10:0] len;
  logic [3:0]  hm, tm;
  logic [1:0]  sk;
  logic [59:0] ssb;
  int          n_viol, n_mismatch, compares;
  rqw_exp_t    expq[$];
  logic [63:0] plq[$];

  rqw_host #(.MAX_PAYLOAD_DW(256), .SB_W(60)) dut_u (
    .clk(clk), .srst(srst), .addr_aligned_mode(mode), .cmd_valid(cv),
    .cmd_ready(cr), .cmd_kind(kind), .cmd_addr(addr), .cmd_mid(mid),
    .cmd_tag(tag), .cmd_msg_code(code), .cmd_msg_route(route), .cmd_tc(tc),
    .cmd_attr(attr), .cmd_digest(dig), .cmd_ltr_snoop(addr[15:0]),
    .cmd_ltr_nosnoop(addr[31:16]), .cmd_flush_code(addr[35:32]),
    .cmd_len_dw(len), .cmd_head_mask(hm), .cmd_tail_mask(tm),
    .cmd_error(cerr), .pl_valid(plv), .pl_ready(plr), .pl_data(pld),
    .pkt_abort(abt), .request_stream_data(sd), .request_stream_valid(sv),
    .request_stream_ready(srdy), .request_stream_last(sl),
    .request_stream_keep(sk), .request_sideband_bus(ssb));

  rqw_dev_model dev_u (.clk(clk), .srst(srst), .valid(sv), .last(sl),
    .keep(sk), .data(sd), .sb(ssb), .ready(srdy), .n_viol(n_viol));

  always #50 clk = ~clk;

  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Payload source: valid whenever a word waits, so no starvation abort
  always @(posedge clk) begin
    if (plv && plr === 1'b1) plq.delete(0);
    #10;
    plv = plq.size() > 0;
    pld = plq.size() > 0 ? plq[0] : '0;
  end

  // Monitor: oldest note against every accepted beat
  always @(posedge clk) begin
    rqw_exp_t    e;
    logic [63:0] m;
    if (abt !== 1'b0 && srst === 1'b0) chk(abt, 1'b0);
    if (sv === 1'b1 && srdy === 1'b1) begin
      if (expq.size() == 0) begin
        chk({sd, sl, sk}, '0);
      end else begin
        e = expq.pop_front();
        m = {{32{e.k[1]}}, 32'hffffffff};
        chk({sd & m, sl, sk}, {e.d & m, e.l, e.k});
        if (e.sbm) chk(ssb[11:0], e.sb);
      end
    end
  end

  // One command, its notes queued before it is offered
  task automatic send(input rqw_kind_t k, input logic [63:0] a, input int n,
                      input logic [3:0] h, input logic [3:0] t, input bit bad);
    logic [31:0]  q[$];
    logic [127:0] ds;
    logic [63:0]  w;
    logic [63:0]  lo;
    rqw_exp_t     e;
    bit           mw;
    mw = (k == RQW_MWR);
    @(posedge clk);
    #10;
    {tag, mid, tc, attr, dig} = 47'({$urandom, $urandom});
    code = mw ? 8'h00 : 8'($urandom);
    route = mw ? 3'h0 : (k == RQW_VDM ? 3'h2 : 3'($urandom));
    kind = k;
    {addr, len, hm, tm, cv} = {a, 11'(n), h, t, 1'b1};
    lo = k == RQW_LTR ? {32'h0, a[31:0]} :
         k == RQW_FLUSH ? {28'h0, a[35:32], 32'h0} : a;
    ds = {dig, attr, tc, 6'h00, route, code, tag, mid[31:11],
          11'((n == 0 && mw) ? 1 : n), lo};
    if (mw && mode && a[2]) q.push_back(32'h0);
    if (mw && n == 0) q.push_back(32'h0);
    for (int i = 0; i < (n + 1) / 2; i++) begin
      w = {$urandom, $urandom};
      plq.push_back(w);
      q.push_back(w[31:0]);
      if (2 * i + 1 < n) q.push_back(w[63:32]);
    end
    e.sb = {1'b0, 3'(mode & a[2]), n > 1 ? t : 4'h0, n > 0 ? h : 4'h0};
    e.sbm = mw;
    {e.d, e.l, e.k} = {ds[63:0], 1'b0, 2'b11};
    if (!bad) expq.push_back(e);
    {e.d, e.l, e.sbm} = {ds[127:64], q.size() == 0, 1'b0};
    if (!bad) expq.push_back(e);
    for (int i = 0; i < q.size(); i += 2) begin
      e.d = {i + 1 < q.size() ? q[i + 1] : 32'h0, q[i]};
      e.k = i + 1 < q.size() ? 2'b11 : 2'b01;
      e.l = i + 2 >= q.size();
      if (!bad) expq.push_back(e);
    end
    if (bad) plq.delete();
    do @(posedge clk); while (cr !== 1'b1);
    #10;
    cv = 1'b0;
    if (bad) begin
      chk(cerr, 1'b1);
    end else begin
      do @(posedge clk); while (cr !== 1'b1);
    end
  endtask

  initial begin
    void'($urandom(6395));
    {clk, srst, mode, cv, addr, mid, tag, code} = '0;
    kind = RQW_MWR;
    {route, tc, attr, dig, len, hm, tm, plv, pld} = '0;
    n_mismatch = 0;
    compares = 0;
    srst = 1'b1;
    repeat (12) @(posedge clk);
    #10;
    srst = 1'b0;
    // Dword-aligned writes: odd masks, one Dword, zero length, odd tail
    send(RQW_MWR, 64'h1000, 2, 4'h5, 4'ha, 0);
    send(RQW_MWR, 64'h2004, 1, 4'hf, 4'hf, 0);
    send(RQW_MWR, 64'h3000, 0, 4'hf, 4'hf, 0);
    send(RQW_MWR, 64'h4008, 5, 4'hc, 4'h3, 0);
    send(RQW_LTR, {$urandom, $urandom}, 0, 4'h0, 4'h0, 0);
    for (int i = 0; i < 3; i++) begin
      send(RQW_FLUSH, {28'h0, (i == 0 ? 4'hf : 4'(2 - i)), 32'h0}, 0,
           4'h0, 4'h0, 0);
    end
    send(RQW_VDM, {$urandom, $urandom}, 0, 4'h0, 4'h0, 0);
    send(RQW_ATS, {$urandom, $urandom}, 0, 4'h0, 4'h0, 0);
    send(RQW_MSG, {$urandom, $urandom}, 2, 4'h0, 4'h0, 0);
    // Refusals: reserved hint, page cross, oversize, broken mask
    send(RQW_FLUSH, 64'h5_0000_0000, 0, 4'h0, 4'h0, 1);
    send(RQW_MWR, 64'h0ffc, 2, 4'hf, 4'hf, 1);
    send(RQW_MWR, 64'h0000, 257, 4'hf, 4'hf, 1);
    send(RQW_MWR, 64'h5000, 3, 4'h5, 4'hf, 1);
    // Mode only flips with the stream drained
    while (expq.size() > 0) @(posedge clk);
    @(posedge clk);
    #10;
    mode = 1'b1;
    send(RQW_MWR, 64'h6004, 3, 4'he, 4'h7, 0);
    send(RQW_MWR, 64'h7004, 2, 4'hf, 4'h1, 0);
    send(RQW_MWR, 64'h8000, 4, 4'hf, 4'hf, 0);
    while (expq.size() > 0) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(n_viol, 0);
    conclude();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    conclude();
  end
endmodule

// *** verilog/rqw_buf.sv ***
`include "rqw_consts.svh"

module rqw_buf #(
  parameter int W = 64
) (
  input  wire  logic         clk,
  input  wire  logic         srst,
  input  wire  logic         in_valid,
  output logic               in_ready,
  input  wire  logic [W-1:0] in_data,
  output logic               out_valid,
  input  wire  logic         out_ready,
  output logic [W-1:0]       out_data,
  output logic [1:0]         fill_level
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] spill;
    logic [1:0]   cnt;
    logic         v;
  } rqw_buf_t;

  rqw_buf_t q;
  rqw_buf_t d;
  logic     pop;

  // Head entry drives the port so outputs stay flop-direct
  always_comb begin
    pop = q.v && out_ready;
    d = q;
    if (pop && q.cnt == 2'h2) begin
      d.head = q.spill;
    end
    if (in_valid) begin
      if (q.cnt == 2'h0 || (q.cnt == 2'h1 && pop)) begin
        d.head = in_data;
      end else begin
        d.spill = in_data;
      end
    end
    d.cnt = q.cnt + 2'(in_valid) - 2'(pop);
    d.v = (d.cnt != 2'h0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready   = (q.cnt != 2'h2);
  assign out_valid  = q.v;
  assign out_data   = q.head;
  assign fill_level = q.cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Writer must never push into a full buffer
  AST_NO_OVERRUN:
    assert property (in_valid |-> in_ready)
      else $error("push into full buffer");
  AST_HOLD_STALLED:
    assert property (out_valid && !out_ready |=>
                     out_valid && $stable(out_data))
      else $error("stream changed while stalled");
  COV_FULL:
    cover property (q.cnt == 2'h2 && !out_ready);

endmodule

// *** verilog/rqw_consts.svh ***
`ifndef RQW_CONSTS_SVH
`define RQW_CONSTS_SVH

// Stream and descriptor geometry
`define RQW_DATA_W         64
`define RQW_DESC_W         128
`define RQW_SB_W           60
`define RQW_MAX_PAYLOAD_DW 256

// Descriptor field positions
`define RQW_DIGEST_BIT     127
`define RQW_ATTR_LSB       124
`define RQW_TC_LSB         121
`define RQW_RID_EN_BIT     120
`define RQW_ROUTE_LSB      112
`define RQW_CODE_LSB       104
`define RQW_TAG_LSB        96
`define RQW_LEN_LSB        64
`define RQW_HI_DW_LSB      32
`define RQW_NOSNOOP_LSB    16

// Buffer flush hint codes and message routing
`define RQW_FLUSH_ACTIVE   4'hf
`define RQW_FLUSH_MEM      4'h1
`define RQW_FLUSH_IDLE     4'h0
`define RQW_ROUTE_BY_ID    3'h2

// Sideband bus field positions
`define RQW_SB_HEAD_LSB    0
`define RQW_SB_TAIL_LSB    4
`define RQW_SB_OFF_LSB     8
`define RQW_SB_DISC_BIT    11

// Address page that a write must not cross
`define RQW_PAGE_BYTES     4096
`define RQW_PAGE_DW        (12'(`RQW_PAGE_BYTES / 4))

`endif

// *** verilog/rqw_desc.sv ***
`include "rqw_consts.svh"

module rqw_desc
  import rqw_pkg::*;
#(
  parameter int MAX_PAYLOAD_DW = `RQW_MAX_PAYLOAD_DW
) (
  input  wire  rqw_kind_t       kind,
  input  wire  logic [63:0]     addr,
  input  wire  logic [31:0]     mid,
  input  wire  logic [7:0]      tag,
  input  wire  logic [7:0]      msg_code,
  input  wire  logic [2:0]      msg_route,
  input  wire  logic [2:0]      tc,
  input  wire  logic [2:0]      attr,
  input  wire  logic            digest,
  input  wire  logic [15:0]     ltr_snoop,
  input  wire  logic [15:0]     ltr_nosnoop,
  input  wire  logic [3:0]      flush_code,
  input  wire  logic [10:0]     len_dw,
  input  wire  logic [3:0]      head_in,
  input  wire  logic [3:0]      tail_in,
  output logic [`RQW_DESC_W-1:0] desc,
  output logic [3:0]            head_mask,
  output logic [3:0]            tail_mask,
  output logic [10:0]           ndw,
  output logic                  ok
);

  logic msg;
  logic head_ok;
  logic tail_ok;
  logic [11:0] page_end;

  // Build the descriptor and screen the command before framing
  always_comb begin
    msg = (kind != RQW_MWR);
    ndw = (kind == RQW_MWR && len_dw == 11'h0) ? 11'h1 : len_dw;
    head_mask = head_in;
    tail_mask = tail_in;
    if (kind == RQW_MWR && len_dw == 11'h0) begin
      head_mask = 4'h0;
      tail_mask = 4'h0;
    end else if (len_dw == 11'h1) begin
      tail_mask = 4'h0;
    end
    desc = '0;
    desc[63:0] = addr;
    desc[95:64] = mid;
    desc[`RQW_LEN_LSB +: 11] = ndw;
    desc[`RQW_TAG_LSB +: 8] = tag;
    case (kind)
      RQW_LTR: begin
        desc[63:0] = {32'h0, ltr_nosnoop, ltr_snoop};
      end
      RQW_FLUSH: begin
        desc[63:0] = {28'h0, flush_code, 32'h0};
      end
      default: begin
      end
    endcase
    if (msg) begin
      desc[`RQW_CODE_LSB +: 8] = msg_code;
      desc[`RQW_ROUTE_LSB +: 3] = msg_route;
    end
    desc[`RQW_TC_LSB +: 3] = tc;
    desc[`RQW_ATTR_LSB +: 3] = attr;
    desc[`RQW_DIGEST_BIT] = digest;
    // Masks longer than two Dwords must be contiguous
    head_ok = (head_mask == 4'hf) || (head_mask == 4'he) ||
              (head_mask == 4'hc) || (head_mask == 4'h8);
    tail_ok = (tail_mask == 4'hf) || (tail_mask == 4'h7) ||
              (tail_mask == 4'h3) || (tail_mask == 4'h1);
    page_end = {2'h0, addr[11:2]} + {1'b0, ndw};
    ok = 1'b1;
    if (kind == RQW_FLUSH && flush_code != `RQW_FLUSH_ACTIVE &&
        flush_code != `RQW_FLUSH_MEM && flush_code != `RQW_FLUSH_IDLE) begin
      ok = 1'b0;
    end
    if (kind == RQW_MWR) begin
      if (32'(ndw) > MAX_PAYLOAD_DW || page_end > `RQW_PAGE_DW) begin
        ok = 1'b0;
      end
      if (ndw > 11'h2 && !(head_ok && tail_ok)) begin
        ok = 1'b0;
      end
    end
  end

endmodule

// *** verilog/rqw_host.sv ***
// Contract
// - Attributes go at bits 124 to 126; ID ordering only on memory or messages.
// - Flush hint code in bits 35:32 is 1111b, 0001b or 0000b only.
// - Vendor message routed by ID carries destination ID in bits 15:0.
// - Dword-aligned write: sixteen descriptor bytes, payload follows directly.
// - Valid stays high for the whole packet; a drop nullifies it.
// - Last marks the final beat of every packet.
// - While ready is low every stream signal holds its value.
// - Keep bits are contiguous ones; zeros only in a short last beat.
// - Head and tail byte masks are valid from the first beat.
// - Payload within maximum size and never across a 4 Kbyte page.
// - Non-contiguous masks only for writes of two Dwords or less.
// - Zero-length write sends one dummy Dword with both masks zero.
// - Single-Dword transfer has tail mask zero; head mask marks bytes.
// - Address-aligned payload starts the beat after the descriptor.
// - Address-aligned payload start offset goes on the sideband field.
`include "rqw_consts.svh"

module rqw_host
  import rqw_pkg::*;
#(
  parameter int MAX_PAYLOAD_DW = `RQW_MAX_PAYLOAD_DW,
  parameter int SB_W           = `RQW_SB_W
) (
  input  wire  logic                  clk,
  input  wire  logic                  srst,
  input  wire  logic                  addr_aligned_mode,
  input  wire  logic                  cmd_valid,
  output logic                        cmd_ready,
  input  wire  rqw_kind_t             cmd_kind,
  input  wire  logic [63:0]           cmd_addr,
  input  wire  logic [31:0]           cmd_mid,
  input  wire  logic [7:0]            cmd_tag,
  input  wire  logic [7:0]            cmd_msg_code,
  input  wire  logic [2:0]            cmd_msg_route,
  input  wire  logic [2:0]            cmd_tc,
  input  wire  logic [2:0]            cmd_attr,
  input  wire  logic                  cmd_digest,
  input  wire  logic [15:0]           cmd_ltr_snoop,
  input  wire  logic [15:0]           cmd_ltr_nosnoop,
  input  wire  logic [3:0]            cmd_flush_code,
  input  wire  logic [10:0]           cmd_len_dw,
  input  wire  logic [3:0]            cmd_head_mask,
  input  wire  logic [3:0]            cmd_tail_mask,
  output logic                        cmd_error,
  input  wire  logic                  pl_valid,
  output logic                        pl_ready,
  input  wire  logic [`RQW_DATA_W-1:0] pl_data,
  output logic                        pkt_abort,
  output logic [`RQW_DATA_W-1:0]      request_stream_data,
  output logic                        request_stream_valid,
  input  wire  logic                  request_stream_ready,
  output logic                        request_stream_last,
  output logic [1:0]                  request_stream_keep,
  output logic [SB_W-1:0]             request_sideband_bus
);

  localparam int BW = `RQW_DATA_W + 3 + SB_W;

  rqw_main_t q;
  rqw_main_t d;

  logic [`RQW_DESC_W-1:0] bd_desc;
  logic [3:0]             bd_head;
  logic [3:0]             bd_tail;
  logic [10:0]            bd_ndw;
  logic                   bd_ok;
  logic                   acc;
  logic                   need;
  logic                   push;
  logic                   pop;
  logic [1:0]             fill;
  logic [1:0]             cnt_next;
  logic [`RQW_DATA_W-1:0] b_data;
  logic [1:0]             b_keep;
  logic                   b_last;
  logic                   b_disc;
  logic [SB_W-1:0]        sb;
  logic [BW-1:0]          buf_out;

  // A beat needs a fresh payload word unless it is the dummy or only the carry remains
  function automatic logic rqw_need(rqw_main_t s);
    return s.has_pl && !s.dummy && !(s.carry_v && s.rem == 12'h1);
  endfunction

  rqw_desc #(
    .MAX_PAYLOAD_DW (MAX_PAYLOAD_DW)
  ) u_desc (
    .kind        (cmd_kind),
    .addr        (cmd_addr),
    .mid         (cmd_mid),
    .tag         (cmd_tag),
    .msg_code    (cmd_msg_code),
    .msg_route   (cmd_msg_route),
    .tc          (cmd_tc),
    .attr        (cmd_attr),
    .digest      (cmd_digest),
    .ltr_snoop   (cmd_ltr_snoop),
    .ltr_nosnoop (cmd_ltr_nosnoop),
    .flush_code  (cmd_flush_code),
    .len_dw      (cmd_len_dw),
    .head_in     (cmd_head_mask),
    .tail_in     (cmd_tail_mask),
    .desc        (bd_desc),
    .head_mask   (bd_head),
    .tail_mask   (bd_tail),
    .ndw         (bd_ndw),
    .ok          (bd_ok)
  );

  // Framing state machine; one beat pushed per granted cycle
  always_comb begin
    d = q;
    d.cmd_error = 1'b0;
    d.pkt_abort = 1'b0;
    acc = (q.st == ST_IDLE) && cmd_valid && q.cmd_ready;
    need = rqw_need(q);
    push = 1'b0;
    b_data = '0;
    b_keep = 2'h3;
    b_last = 1'b0;
    b_disc = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (acc && !bd_ok) begin
          d.cmd_error = 1'b1;
        end else if (acc) begin
          d.desc = bd_desc;
          d.hmask = bd_head;
          d.tmask = bd_tail;
          d.off = addr_aligned_mode && cmd_kind == RQW_MWR &&
                  cmd_addr[2];
          d.has_pl = (cmd_kind == RQW_MWR) || (cmd_len_dw != 11'h0);
          d.dummy = (cmd_kind == RQW_MWR) && (cmd_len_dw == 11'h0);
          d.rem = 12'(bd_ndw) + 12'(d.off);
          d.fill = d.off;
          d.carry_v = 1'b0;
          d.st = ST_DESC0;
        end
      end
      ST_DESC0: begin
        if (q.push_ok) begin
          push = 1'b1;
          b_data = q.desc[63:0];
          d.st = ST_DESC1;
        end
      end
      ST_DESC1: begin
        if (q.push_ok) begin
          push = 1'b1;
          b_data = q.desc[127:64];
          b_last = !q.has_pl;
          d.st = q.has_pl ? ST_DATA : ST_IDLE;
        end
      end
      ST_DATA: begin
        if (q.push_ok && need && !pl_valid) begin
          // Source ran dry: end now with discontinue, keep valid high
          push = 1'b1;
          b_last = 1'b1;
          b_disc = 1'b1;
          d.pkt_abort = 1'b1;
          d.st = ST_IDLE;
        end else if (q.push_ok) begin
          push = 1'b1;
          if (q.dummy) begin
            b_data = '0;
          end else if (q.fill) begin
            b_data = {pl_data[31:0], 32'h0};
            d.carry = pl_data[63:32];
            d.carry_v = 1'b1;
            d.fill = 1'b0;
          end else if (q.carry_v) begin
            b_data = {(q.rem > 12'h1) ? pl_data[31:0] : 32'h0, q.carry};
            d.carry = pl_data[63:32];
          end else begin
            b_data = pl_data;
          end
          b_keep = (q.rem == 12'h1) ? 2'h1 : 2'h3;
          b_last = (q.rem <= 12'h2);
          d.rem = (q.rem > 12'h2) ? q.rem - 12'h2 : 12'h0;
          if (b_last) begin
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Predict room one cycle ahead so grants can be registered
    pop = request_stream_valid && request_stream_ready;
    cnt_next = fill + 2'(push) - 2'(pop);
    d.push_ok = (cnt_next != 2'h2);
    d.cmd_ready = (d.st == ST_IDLE);
    d.pl_ready = (d.st == ST_DATA) && d.push_ok && rqw_need(d);
  end

  // Masks and offset stay constant for the whole packet; discontinue is set only on an aborted last beat
  always_comb begin
    sb = '0;
    sb[`RQW_SB_HEAD_LSB +: 4] = q.hmask;
    sb[`RQW_SB_TAIL_LSB +: 4] = q.tmask;
    sb[`RQW_SB_OFF_LSB +: 3] = {2'h0, q.off};
    sb[`RQW_SB_DISC_BIT] = b_disc;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{st: ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // Two-entry buffer absorbs a stall without losing a beat
  rqw_buf #(
    .W (BW)
  ) u_buf (
    .clk        (clk),
    .srst       (srst),
    .in_valid   (push),
    .in_ready   (),
    .in_data    ({b_data, b_keep, b_last, sb}),
    .out_valid  (request_stream_valid),
    .out_ready  (request_stream_ready),
    .out_data   (buf_out),
    .fill_level (fill)
  );

  assign {request_stream_data, request_stream_keep, request_stream_last,
          request_sideband_bus} = buf_out;
  assign cmd_ready = q.cmd_ready;
  assign pl_ready  = q.pl_ready;
  assign cmd_error = q.cmd_error;
  assign pkt_abort = q.pkt_abort;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_VALID_HOLD:
    assert property (request_stream_valid &&
                     !(request_stream_ready && request_stream_last) |=>
                     request_stream_valid)
      else $error("valid dropped inside a packet");
  AST_KEEP_CONTIG:
    assert property (request_stream_valid |-> request_stream_keep[0] &&
                     (request_stream_last || request_stream_keep[1]))
      else $error("keep not contiguous");
  AST_LAST_FINAL:
    assert property (push && q.st == ST_DATA && q.rem <= 12'h2 |-> b_last)
      else $error("final beat without last");
  AST_SB_STABLE:
    assert property (request_stream_valid && !request_stream_last |=>
                     $stable(request_sideband_bus[7:0]))
      else $error("byte masks moved inside a packet");
  AST_UPPER:
    assert property (acc && bd_ok |=>
                     q.desc[127:121] == {$past(cmd_digest),
                     $past(cmd_attr), $past(cmd_tc)})
      else $error("attribute, digest or class misplaced");
  AST_LTR:
    assert property (acc && bd_ok && cmd_kind == RQW_LTR |=>
                     q.desc[31:0] == {$past(cmd_ltr_nosnoop),
                     $past(cmd_ltr_snoop)})
      else $error("latency fields misplaced");
  AST_FLUSH_CODE:
    assert property (acc && cmd_kind == RQW_FLUSH && cmd_flush_code !=
                     4'hf && cmd_flush_code > 4'h1 |=> cmd_error ##1 cmd_ready)
      else $error("reserved flush code not refused");
  AST_MSG:
    assert property (acc && bd_ok && cmd_kind != RQW_MWR |=>
                     q.desc[114:104] == {$past(cmd_msg_route),
                     $past(cmd_msg_code)})
      else $error("message code or routing misplaced");
  AST_HDR_WORDS:
    assert property (acc && bd_ok && (cmd_kind == RQW_VDM ||
                     cmd_kind == RQW_ATS) |=>
                     q.desc[63:0] == $past(cmd_addr))
      else $error("header words not copied");
  AST_DESC_THEN_DATA:
    assert property (push && q.st == ST_DESC1 && q.has_pl |=>
                     q.st == ST_DATA)
      else $error("payload does not follow descriptor");
  AST_PAGE:
    assert property (acc && cmd_kind == RQW_MWR && cmd_addr[11:2] ==
                     10'h3ff && cmd_len_dw == 11'h2 |=> cmd_error)
      else $error("page crossing not refused");
  AST_CONTIG:
    assert property (acc && bd_ok && cmd_kind == RQW_MWR &&
                     cmd_len_dw > 11'h2 |=> q.hmask[3] && q.tmask[0])
      else $error("gapped masks on long write");
  AST_ZERO_LEN:
    assert property (acc && bd_ok && cmd_kind == RQW_MWR &&
                     cmd_len_dw == 11'h0 |=> q.dummy && q.hmask == 4'h0 &&
                     q.rem == 12'(1 + q.off) && q.tmask == 4'h0)
      else $error("zero-length write not padded");
  AST_SINGLE:
    assert property (acc && bd_ok && cmd_len_dw == 11'h1 |=>
                     q.tmask == 4'h0 && q.hmask == $past(cmd_head_mask))
      else $error("single Dword tail mask not zero");
  AST_ALIGN_OFF:
    assert property (acc && bd_ok && addr_aligned_mode &&
                     cmd_kind == RQW_MWR |=> q.off == $past(cmd_addr[2])
                     && q.fill == q.off)
      else $error("payload offset wrong");

  COV_ZERO_LEN:
    cover property (acc && bd_ok && cmd_len_dw == 11'h0);
  COV_ALIGNED:
    cover property (push && q.st == ST_DATA && q.fill);
  COV_ABORT:
    cover property (pkt_abort);
  COV_STALL:
    cover property (request_stream_valid && !request_stream_ready);

endmodule

// *** verilog/rqw_pkg.sv ***
`include "rqw_consts.svh"

package rqw_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DESC0 = 4'h2,
    ST_DESC1 = 4'h4,
    ST_DATA  = 4'h8
  } rqw_state_t;

  typedef enum logic [2:0] {
    RQW_MWR   = 3'h0,
    RQW_MSG   = 3'h1,
    RQW_LTR   = 3'h2,
    RQW_FLUSH = 3'h3,
    RQW_VDM   = 3'h4,
    RQW_ATS   = 3'h5
  } rqw_kind_t;

  typedef struct packed {
    rqw_state_t                 st;
    logic [`RQW_DESC_W-1:0]     desc;
    logic [3:0]                 hmask;
    logic [3:0]                 tmask;
    logic                       off;
    logic                       dummy;
    logic                       has_pl;
    logic [11:0]                rem;
    logic [31:0]                carry;
    logic                       carry_v;
    logic                       fill;
    logic                       cmd_ready;
    logic                       pl_ready;
    logic                       push_ok;
    logic                       cmd_error;
    logic                       pkt_abort;
  } rqw_main_t;

endpackage
